/* hdl/pmf_fabric.sv */
// macrocell fabric: matrix, AND arrays, macrocells, fast decode and compare
`timescale 1ns/1ps
`default_nettype none
module pmf_fabric
    import pmf_pkg::*;
#(
    parameter int CFG_CYCLES = CFG_CYC
) (
    // clock and master reset
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // static configuration
    input  wire logic [UIM_OUT*UIM_IN-1:0]     cfg_uim_conn,
    input  wire logic [NUM_FB*PT_FB*LIT-1:0]   cfg_pt_mask,
    input  wire logic [NUM_MC*MCW-1:0]         cfg_mc,
    input  wire logic [DEC_N*FD_W-1:0]         cfg_dec_val,
    input  wire logic [DEC_N*FD_W-1:0]         cfg_dec_dc,
    input  wire logic [DEC_N-1:0]              cfg_dec_inv,
    input  wire logic [CMP_N*FD_W-1:0]         cfg_cmp_pre,
    input  wire logic [CMP_N*FD_W-1:0]         cfg_cmp_dc,
    input  wire logic [CMP_N*DEC_N-1:0]        cfg_cmp_qual,
    input  wire logic [CMP_N-1:0]              cfg_cmp_inv,
    // input pins
    input  wire logic [1:0]                    global_fast_clock,
    input  wire logic [FI_N-1:0]               fast_input_pins,
    input  wire logic [PIN_IN-1:0]             input_pins,
    input  wire logic [FD_W-1:0]               decoder_inputs,
    input  wire logic [FD_W-1:0]               comparator_inputs,
    input  wire logic                          cmp_latch_en,
    input  wire logic [CMP_N-1:0]              cmp_disable,
    // macrocell pins
    output logic      [NUM_MC-1:0]             mc_pin_out,
    output logic      [NUM_MC-1:0]             mc_pin_oe,
    // fast paths and status
    output logic      [DEC_N-1:0]              decoder_match_out,
    output logic      [CMP_N-1:0]              comparator_match_out,
    output logic                               cfg_busy
);
    // ************************************************************
    // configuration period
    // ************************************************************
    logic [CFG_CNT_W-1:0] cfg_cnt;
    wire                  cfg_end = cfg_cnt == CFG_CNT_W'(CFG_CYCLES - 1);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_cnt  <= '0;
            cfg_busy <= 1'b1;
        end else if (cfg_busy) begin
            cfg_cnt  <= cfg_cnt + 1'b1;
            cfg_busy <= !cfg_end;
        end
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [ASYNC_W-1:0] meta;
    logic [ASYNC_W-1:0] syn;
    logic [1:0]         gclk_s;
    logic [1:0]         gprev;
    logic [FI_N-1:0]    fi_s;
    logic [PIN_IN-1:0]  pin_s;
    logic [FD_W-1:0]    dec_s;
    logic [FD_W-1:0]    cmp_s;
    logic               le_s;
    logic [CMP_N-1:0]   dis_s;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta  <= '0;
            syn   <= '0;
            gprev <= '0;
        end else begin
            meta  <= {global_fast_clock, fast_input_pins, input_pins,
                      decoder_inputs, comparator_inputs, cmp_latch_en,
                      cmp_disable};
            syn   <= meta;
            gprev <= gclk_s;
        end
    end

    assign {gclk_s, fi_s, pin_s, dec_s, cmp_s, le_s, dis_s} = syn;
    wire [1:0] g_rise = gclk_s & ~gprev;

    // ************************************************************
    // central interconnect matrix
    // ************************************************************
    logic [NUM_MC-1:0]  mc_fb;
    logic [UIM_OUT-1:0] uim_out;
    wire  [UIM_IN-1:0]  uim_in = {pin_s, mc_fb};

    for (genvar o = 0; o < UIM_OUT; o++) begin : g_uim
        // unconnected lines read high
        assign uim_out[o] = &(uim_in | ~cfg_uim_conn[o*UIM_IN +: UIM_IN]);
    end

    // ************************************************************
    // function block AND arrays
    // ************************************************************
    logic [NUM_FB*PT_FB-1:0] pterm;

    for (genvar f = 0; f < NUM_FB; f++) begin : g_fb
        logic [LIT/2-1:0] x;
        if (f < FB_WITH_FI) begin : g_fi
            assign x = {fi_s[f*FB_FI +: FB_FI], uim_out[f*FB_UIM +: FB_UIM]};
        end else begin : g_nofi
            assign x = {{FB_FI{1'b0}}, uim_out[f*FB_UIM +: FB_UIM]};
        end
        wire [LIT-1:0] lit = {~x, x};
        for (genvar p = 0; p < PT_FB; p++) begin : g_pt
            assign pterm[f*PT_FB+p] =
                &(lit | ~cfg_pt_mask[(f*PT_FB+p)*LIT +: LIT]);
        end
    end

    // ************************************************************
    // macrocells
    // ************************************************************
    logic [NUM_MC:0]   cy;
    logic [NUM_MC-1:0] mc_q;
    logic [NUM_MC-1:0] rst_v;
    logic [NUM_MC-1:0] set_v;
    logic [NUM_MC-1:0] oe_v;
    logic [NUM_MC-1:0] d_v;
    logic [NUM_MC-1:0] tr_v;
    logic [NUM_MC-1:0] edge_v;

    // subtraction needs a carry of one into the bottom of the chain
    assign cy[0] = cfg_mc[SUB];

    for (genvar i = 0; i < NUM_MC; i++) begin : g_mc
        localparam int F = i / MC_PER_FB;
        localparam int M = i % MC_PER_FB;
        wire [MCW-1:0]     c  = cfg_mc[i*MCW +: MCW];
        wire [PT_PRIV-1:0] pp = pterm[F*PT_FB+M*PT_PRIV +: PT_PRIV];
        wire [PT_SHR-1:0]  sp = pterm[F*PT_FB+SHR_BASE +: PT_SHR];
        wire [3:0]         lt = c[LUT +: 4];
        wire [1:0]         ck = c[CKSEL +: 2];
        logic q_r;
        logic pq_r;
        logic fb_r;
        logic po_r;
        logic oe_r;

        wire pclk  = c[USE_CLK] & pp[0];
        wire rst_t = c[USE_RST] & pp[1];
        wire set_t = c[USE_SET] & pp[2];
        wire oe_t  = !c[USE_OE] | pp[3];
        // terms taken for control drop out of operand A
        wire [3:0] apv = pp[3:0] &
            ~{c[USE_OE], c[USE_SET], c[USE_RST], c[USE_CLK]};
        wire alu_operand_a = (|apv) | (|(sp[3:0] & c[A_SEL +: 4]));
        wire tgl = c[FB_EN] & q_r & (&(sp[11:9] | ~c[FB_SEL +: 3]));
        wire alu_operand_b = pp[4] | (|(sp[11:4] & c[B_SEL +: 8]))
                             | tgl;
        wire bb  = alu_operand_b ^ c[SUB];
        wire sum = alu_operand_a ^ bb ^ cy[i];
        assign cy[i+1] = (alu_operand_a & bb) | (cy[i] & (alu_operand_a ^ bb));
        wire lut = lt[{alu_operand_a, alu_operand_b}];
        wire d   = c[ARITH] ? sum : lut;
        wire clk_edge = (ck == CK_PT) ? (pclk & !pq_r) :
                        (ck == CK_G0) ? g_rise[0] : g_rise[1];
        wire val = c[TRANSP] ? d : q_r;

        always_ff @(posedge core_clk) begin
            if (!rst_n || cfg_busy) begin
                q_r  <= c[PRELOAD];
                pq_r <= 1'b0;
                fb_r <= 1'b1;
                po_r <= 1'b0;
                oe_r <= 1'b0;
            end else begin
                pq_r <= pclk;
                if (rst_t) begin
                    q_r <= 1'b0;
                end else if (set_t) begin
                    q_r <= 1'b1;
                end else if (clk_edge) begin
                    q_r <= d;
                end
                fb_r <= oe_t ? val : 1'b1;
                po_r <= val;
                oe_r <= oe_t;
            end
        end

        assign mc_q[i]       = q_r;
        assign mc_fb[i]      = fb_r;
        assign mc_pin_out[i] = po_r;
        assign mc_pin_oe[i]  = oe_r;
        assign rst_v[i]      = rst_t;
        assign set_v[i]      = set_t;
        assign oe_v[i]       = oe_t;
        assign d_v[i]        = d;
        assign tr_v[i]       = c[TRANSP];
        assign edge_v[i]     = clk_edge;
    end

    // ************************************************************
    // fast decoder unit and fast comparator unit
    // ************************************************************
    logic [DEC_N-1:0]      dec_hit;
    logic [CMP_N-1:0]      cmp_hit;
    logic [CMP_N*FD_W-1:0] cmp_lat;

    for (genvar k = 0; k < DEC_N; k++) begin : g_dec
        assign dec_hit[k] = &(~(dec_s ^ cfg_dec_val[k*FD_W +: FD_W])
                              | cfg_dec_dc[k*FD_W +: FD_W]);
    end

    for (genvar j = 0; j < CMP_N; j++) begin : g_cmp
        wire pat  = &(~(cmp_s ^ cmp_lat[j*FD_W +: FD_W])
                      | cfg_cmp_dc[j*FD_W +: FD_W]);
        wire qual = &(dec_hit | ~cfg_cmp_qual[j*DEC_N +: DEC_N]);
        assign cmp_hit[j] = pat & qual & !dis_s[j];
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || cfg_busy) begin
            cmp_lat              <= cfg_cmp_pre;
            decoder_match_out    <= '0;
            comparator_match_out <= '0;
        end else begin
            if (le_s) begin
                cmp_lat <= {CMP_N{cmp_s}};
            end
            decoder_match_out    <= dec_hit ^ cfg_dec_inv;
            comparator_match_out <= cmp_hit ^ cfg_cmp_inv;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_cfg_out;
        @(posedge core_clk) disable iff (!rst_n)
        cfg_busy |=> mc_pin_oe == '0;
    endproperty
    a_cfg_out: assert property (p_cfg_out) else $error("pin enabled in config");

    property p_cfg_len;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> cfg_busy [*8];
    endproperty
    a_cfg_len: assert property (p_cfg_len) else $error("config period short");

    property p_preload;
        @(posedge core_clk) disable iff (!rst_n)
        cfg_busy && $past(cfg_busy) |-> mc_q[0] == cfg_mc[PRELOAD];
    endproperty
    a_preload: assert property (p_preload) else $error("preload not loaded");

    property p_rst_wins;
        @(posedge core_clk) disable iff (!rst_n)
        !cfg_busy && rst_v[0] |=> !mc_q[0];
    endproperty
    a_rst_wins: assert property (p_rst_wins) else $error("reset not winning");

    property p_set;
        @(posedge core_clk) disable iff (!rst_n)
        !cfg_busy && set_v[0] && !rst_v[0] |=> mc_q[0];
    endproperty
    a_set: assert property (p_set) else $error("set not applied");

    property p_capture;
        @(posedge core_clk) disable iff (!rst_n)
        !cfg_busy && !rst_v[0] && !set_v[0] && edge_v[0]
            |=> mc_q[0] == $past(d_v[0]);
    endproperty
    a_capture: assert property (p_capture) else $error("edge not captured");

    property p_transp;
        @(posedge core_clk) disable iff (!rst_n)
        !cfg_busy && tr_v[0] |=> mc_pin_out[0] == $past(d_v[0]);
    endproperty
    a_transp: assert property (p_transp) else $error("not transparent");

    property p_oe_z;
        @(posedge core_clk) disable iff (!rst_n)
        !cfg_busy && !oe_v[0] |=> !mc_pin_oe[0] && mc_fb[0];
    endproperty
    a_oe_z: assert property (p_oe_z) else $error("disabled pin driven");

    property p_dec;
        @(posedge core_clk) disable iff (!rst_n)
        !cfg_busy ##1 !cfg_busy |->
            decoder_match_out == $past(dec_hit ^ cfg_dec_inv);
    endproperty
    a_dec: assert property (p_dec) else $error("decoder output wrong");

    property p_cmp_dis;
        @(posedge core_clk) disable iff (!rst_n)
        !cfg_busy && dis_s[0] |=>
            comparator_match_out[0] == $past(cfg_cmp_inv[0]);
    endproperty
    a_cmp_dis: assert property (p_cmp_dis) else $error("disable ignored");

endmodule
`default_nettype wire

/* hdl/pmf_pkg.sv */
// constants and configuration field layout for the macrocell fabric
package pmf_pkg;
    localparam int NUM_MC     = 36;
    localparam int NUM_FB     = 4;
    localparam int MC_PER_FB  = 9;
    localparam int UIM_IN     = 68;
    localparam int UIM_OUT    = 84;
    localparam int FB_UIM     = 21;
    localparam int FB_FI      = 3;
    localparam int FB_WITH_FI = 3;
    localparam int FI_N       = 9;
    localparam int PIN_IN     = 32;
    localparam int PT_PRIV    = 5;
    localparam int PT_SHR     = 12;
    localparam int SHR_BASE   = 45;
    localparam int PT_FB      = 57;
    localparam int LIT        = 48;
    localparam int DEC_N      = 4;
    localparam int CMP_N      = 2;
    localparam int FD_W       = 6;
    localparam int ASYNC_W    = 58;
    // macrocell configuration word fields
    localparam int A_SEL      = 0;
    localparam int B_SEL      = 4;
    localparam int USE_CLK    = 12;
    localparam int USE_RST    = 13;
    localparam int USE_SET    = 14;
    localparam int USE_OE     = 15;
    localparam int FB_EN      = 16;
    localparam int FB_SEL     = 17;
    localparam int ARITH      = 20;
    localparam int SUB        = 21;
    localparam int LUT        = 22;
    localparam int CKSEL      = 26;
    localparam int TRANSP     = 28;
    localparam int PRELOAD    = 29;
    localparam int MCW        = 30;
    // clock select codes
    localparam logic [1:0] CK_PT = 2'h0;
    localparam logic [1:0] CK_G0 = 2'h1;
    // configuration period
    localparam int CFG_US     = 350;
    localparam int CLK_MHZ    = 20;
    localparam int CFG_CYC    = CFG_US * CLK_MHZ;
    localparam int CFG_CNT_W  = 13;
endpackage

/* testbench/pmf_fabric_tb.sv */
// self-checking bench for the macrocell fabric
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
n_mismatch++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module pmf_fabric_tb
    import pmf_pkg::*;
;
    // ****************************************
    // signals
    // ****************************************
    localparam int             CYC  = 16;
    localparam int             LIM  = 20000;
    localparam logic [LIT-1:0] ZERO = 48'h1000001;
    logic                        core_clk;
    logic                        rst_n = 1'b0;
    logic [UIM_OUT*UIM_IN-1:0]   cfg_uim_conn = '0, uim_s = '0;
    logic [NUM_FB*PT_FB*LIT-1:0] cfg_pt_mask = '0, pt_s = '0;
    logic [NUM_MC*MCW-1:0]       cfg_mc = '0, mc_s = '0;
    logic [23:0]                 cfg_dec_val = {6'h2a, 6'h15, 6'h33, 6'h0c};
    logic [23:0]                 cfg_dec_dc = {6'h3f, 6'h30, 6'h03, 6'h00};
    logic [3:0]                  cfg_dec_inv = 4'h4, dinv_s = 4'h4;
    logic [11:0]                 cfg_cmp_pre = {6'h0c, 6'h21};
    logic [11:0]                 cfg_cmp_dc = {6'h00, 6'h01};
    logic [7:0]                  cfg_cmp_qual = 8'h01, cq_s = 8'h01;
    logic [1:0]                  cfg_cmp_inv = 2'h2, cinv_s = 2'h2;
    logic [1:0]                  global_fast_clock = '0, gck_s = '0;
    logic [FI_N-1:0]             fast_input_pins = '0, fi_s = '0;
    logic [PIN_IN-1:0]           input_pins = '0, pin_s = '0;
    logic [5:0]                  decoder_inputs = '0, di_s = '0;
    logic [5:0]                  comparator_inputs = '0, ci_s = '0;
    logic                        cmp_latch_en = 1'b0, le_s = 1'b0;
    logic [1:0]                  cmp_disable = '0, dis_s = '0;
    logic [NUM_MC-1:0]           mc_pin_out, mc_pin_oe;
    logic [3:0]                  decoder_match_out;
    logic [1:0]                  comparator_match_out;
    logic                        cfg_busy;
    logic [5:0]                  lat [2] = '{6'h21, 6'h0c};
    int                          n_mismatch = 0, num_checks = 0, cyc = 0;

    pmf_fabric #(.CFG_CYCLES(CYC)) pmf_fabric_inst (
        .core_clk, .rst_n, .cfg_uim_conn, .cfg_pt_mask, .cfg_mc,
        .cfg_dec_val, .cfg_dec_dc, .cfg_dec_inv, .cfg_cmp_pre, .cfg_cmp_dc,
        .cfg_cmp_qual, .cfg_cmp_inv, .global_fast_clock, .fast_input_pins,
        .input_pins, .decoder_inputs, .comparator_inputs, .cmp_latch_en,
        .cmp_disable, .mc_pin_out, .mc_pin_oe, .decoder_match_out,
        .comparator_match_out, .cfg_busy
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // shadows reach the pins on the rising edge only
    always @(posedge core_clk) begin
        cfg_uim_conn      <= uim_s;
        cfg_pt_mask       <= pt_s;
        cfg_mc            <= mc_s;
        cfg_dec_inv       <= dinv_s;
        cfg_cmp_qual      <= cq_s;
        cfg_cmp_inv       <= cinv_s;
        global_fast_clock <= gck_s;
        fast_input_pins   <= fi_s;
        input_pins        <= pin_s;
        decoder_inputs    <= di_s;
        comparator_inputs <= ci_s;
        cmp_latch_en      <= le_s;
        cmp_disable       <= dis_s;
        cyc <= cyc + 1;
        if (cyc == LIM) begin
            n_mismatch++;
            final_report();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [MCW-1:0] mk(logic [3:0] lut, logic ar, sb,
        logic [1:0] ck, logic tr, pl, logic [3:0] u);
        return {pl, tr, ck, lut, sb, ar, 4'h0, u, 12'h0};
    endfunction

    function automatic logic [3:0] dhit(logic [5:0] d);
        for (int k = 0; k < DEC_N; k++)
            dhit[k] = ((d ^ cfg_dec_val[k*6+:6]) & ~cfg_dec_dc[k*6+:6]) == 0;
    endfunction

    function automatic logic [1:0] cexp();
        for (int j = 0; j < CMP_N; j++)
            cexp[j] = ((((ci_s ^ lat[j]) & ~cfg_cmp_dc[j*6+:6]) == 6'h0)
                && ((cfg_cmp_qual[j*4+:4] & ~dhit(di_s)) == 4'h0)
                && !dis_s[j]) ^ cfg_cmp_inv[j];
    endfunction

    task automatic st(int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic pulse(int k);
        for (int v = 1; v >= 0; v--) begin
            if (k < 2) gck_s[k] = 1'(v);
            else pin_s[k] = 1'(v);
            st(3);
        end
    endtask

    task automatic pt(int p, logic [LIT-1:0] m);
        pt_s[p*LIT+:LIT] = m;
    endtask

    task automatic cn(int o, int n, logic v);
        uim_s[o*UIM_IN+n] = v;
    endtask

    task automatic dsweep(logic [3:0] inv);
        dinv_s = inv;
        for (int d = 0; d < 64; d++) begin
            di_s = 6'(d);
            st(5);
            `CHK("dec", dhit(di_s) ^ cfg_dec_inv, decoder_match_out)
        end
    endtask

    task automatic csweep();
        for (int i = 0; i < 256; i++) begin
            ci_s = 6'(i >> 2);
            di_s = i[0] ? 6'h0c : 6'h0d;
            dis_s = i[1] ? ~cinv_s : 2'h0;
            st(5);
            `CHK("cmp", cexp(), comparator_match_out)
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        int n;
        mc_s[0+:MCW] = mk(4'hc, 0, 0, CK_G0, 0, 1, 4'h0);
        mc_s[MCW+:MCW] = mk(4'hc, 0, 0, CK_G0, 0, 0, 4'h0);
        for (int p = 0; p < 4; p++)
            pt(p, 48'h1);
        pt(4, 48'h2);
        cn(0, 36, 1'b1);
        cn(1, 37, 1'b1);
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("busy", 1'b1, cfg_busy)
        `CHK("oe_rst", 36'h0, mc_pin_oe)
        @(posedge core_clk);
        rst_n <= 1'b1;
        n = 0;
        pin_s = '1;
        di_s = 6'h0c;
        do begin
            @(posedge core_clk);
            n++;
            @(negedge core_clk);
            if (cfg_busy === 1'b1) begin
                `CHK("oe_cfg", 36'h0, mc_pin_oe)
                `CHK("dec_cfg", 4'h0, decoder_match_out)
            end
        end while (cfg_busy === 1'b1 && n < 100);
        `CHK("cfg_len", CYC, n)
        pin_s = '0;
        st(6);
        `CHK("preload", 2'b01, mc_pin_out[1:0])
        `CHK("oe_on", 1'b1, mc_pin_oe[0])
        pulse(0);
        `CHK("ff_clk0", 1'b0, mc_pin_out[0])
        pin_s[0] = 1'b1;
        st(6);
        `CHK("ff_hold", 1'b0, mc_pin_out[0])
        pulse(0);
        `CHK("ff_clk0", 1'b1, mc_pin_out[0])
        mc_s[0+:MCW] = mk(4'hc, 0, 0, 2'h2, 0, 0, 4'h0);
        pin_s[0] = 1'b0;
        pulse(0);
        `CHK("ff_other", 1'b1, mc_pin_out[0])
        pulse(1);
        `CHK("ff_clk1", 1'b0, mc_pin_out[0])
        mc_s[0+:MCW] = mk(4'hc, 0, 0, CK_PT, 0, 0, 4'h1);
        pt(0, 48'h40);
        cn(6, 42, 1'b1);
        pin_s[0] = 1'b1;
        st(6);
        `CHK("ff_pt_hold", 1'b0, mc_pin_out[0])
        pulse(6);
        `CHK("ff_pt_clk", 1'b1, mc_pin_out[0])
        mc_s[0+:MCW] = mk(4'hc, 0, 0, CK_G0, 0, 0, 4'h6);
        pt(0, 48'h1);
        pt(1, 48'h4);
        pt(2, 48'h8);
        cn(2, 38, 1'b1);
        cn(3, 39, 1'b1);
        pin_s[0] = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pin_s[2] = 1'(4'ha >> i);
            pin_s[3] = 1'(4'h7 >> i);
            st(6);
            `CHK("set_rst", ~pin_s[2], mc_pin_out[0])
        end
        pin_s[3:2] = 2'h0;
        mc_s[0+:MCW] = mk(4'hc, 0, 0, CK_G0, 1, 0, 4'he);
        mc_s[MCW+:MCW] = mk(4'hc, 0, 0, CK_G0, 1, 0, 4'h0);
        pt(3, 48'h10);
        cn(4, 40, 1'b1);
        for (int p = 5; p < 9; p++)
            pt(p, 48'h20);
        pt(9, ZERO);
        cn(5, 0, 1'b1);
        for (int p = 0; p < 2; p++) begin
            pin_s[4] = 1'(p);
            st(8);
            `CHK("oe", 1'(p), mc_pin_oe[0])
            `CHK("fb_off_high", ~pin_s[4], mc_pin_out[1])
        end
        for (int p = 1; p < 4; p++)
            pt(p, 48'h1);
        for (int l = 0; l < 16; l++)
            for (int ab = 0; ab < 4; ab++) begin
                mc_s[0+:MCW] = mk(4'(l), 0, 0, CK_G0, 1, 0, 4'h0);
                pin_s[1:0] = {ab[0], ab[1]};
                st(6);
                `CHK("lut", 1'(l >> ab), mc_pin_out[0])
            end
        cn(0, 41, 1'b1);
        mc_s[0+:MCW] = mk(4'hc, 0, 0, CK_G0, 1, 0, 4'h0);
        for (int ab = 0; ab < 4; ab++) begin
            {pin_s[0], pin_s[5]} = 2'(ab);
            st(6);
            `CHK("uim_and", &2'(ab), mc_pin_out[0])
        end
        cn(0, 41, 1'b0);
        mc_s[0+:MCW] = mk(4'h6, 0, 0, CK_G0, 0, 0, 4'h0);
        mc_s[FB_EN] = 1'b1;
        mc_s[FB_SEL+:3] = 3'h7;
        pt(4, ZERO);
        for (int p = 54; p < 57; p++)
            pt(p, 48'h2);
        pin_s[1:0] = 2'h1;
        for (int i = 0; i < 3; i++) begin
            pulse(0);
            `CHK("toggle", !i[0], mc_pin_out[0])
            pin_s[1] = 1'b1;
        end
        pt(4, 48'h2);
        mc_s[MCW+:MCW] = mk(4'h0, 1, 0, CK_G0, 1, 0, 4'h0);
        for (int p = 5; p < 10; p++)
            pt(p, ZERO);
        for (int i = 0; i < 8; i++) begin
            mc_s[0+:MCW] = mk(4'h0, 1, i[2], CK_G0, 1, 0, 4'h0);
            pin_s[1:0] = {i[0], i[1]};
            st(6);
            `CHK("sum", i[1] ^ i[0], mc_pin_out[0])
            `CHK("carry", i[2] ? i[1] | !i[0] : i[1] & i[0],
                mc_pin_out[1])
        end
        mc_s[0+:MCW] = mk(4'hc, 0, 0, CK_G0, 1, 0, 4'h0);
        for (int p = 0; p < 4; p++)
            pt(p, 48'h200000);
        pt(4, ZERO);
        for (int p = 0; p < 2; p++) begin
            fi_s[0] = 1'(p);
            st(6);
            `CHK("fast_in", 1'(p), mc_pin_out[0])
        end
        dsweep(4'h4);
        dsweep(4'ha);
        csweep();
        ci_s = 6'h15;
        le_s = 1'b1;
        st(4);
        le_s = 1'b0;
        st(2);
        lat = '{6'h15, 6'h15};
        cinv_s = 2'h1;
        cq_s = 8'h10;
        csweep();
        final_report();
    end
endmodule
`default_nettype wire
